// ===== rtl/scc_pkg.sv
// Package of constants for the system clock control unit
package scc_pkg;
    localparam logic [15:0] SCC_CTRL0_ADDR  = 16'h0006;
    localparam logic [15:0] SCC_CTRL1_ADDR  = 16'h0007;
    localparam logic [15:0] SCC_PROT_ADDR   = 16'h000a;
    localparam logic [15:0] SCC_DETECT_ADDR = 16'h000c;
    localparam logic [7:0]  SCC_CTRL0_RST   = 8'h68;
    localparam logic [7:0]  SCC_CTRL1_RST   = 8'h20;
    localparam logic [7:0]  SCC_DETECT_RST  = 8'h04;
    localparam logic [7:0]  SCC_CTRL0_FIXED = 8'h08;
    localparam logic [7:0]  SCC_CTRL0_MASK  = 8'h64;
    localparam logic [7:0]  SCC_CTRL1_MASK  = 8'hf9;
    // Control 0 fields
    localparam int SCC_WAIT_PSTOP = 2;
    localparam int SCC_MAIN_STOP  = 5;
    localparam int SCC_DIV_SEL0   = 6;
    // Control 1 fields
    localparam int SCC_ALL_STOP   = 0;
    localparam int SCC_PIN_SWITCH = 3;
    localparam int SCC_LOW_STOP   = 4;
    localparam int SCC_DRIVE      = 5;
    localparam int SCC_DIV_LO     = 6;
    localparam int SCC_DIV_HI     = 7;
    // Protect and detect fields
    localparam int SCC_CLK_WEN    = 0;
    localparam int SCC_DET_LO     = 0;
    localparam int SCC_DET_HI     = 1;
    localparam int SCC_SRC_SEL    = 2;
    localparam int SCC_MAIN_STS   = 3;
    // Divider width: largest division 32
    localparam int SCC_DIV_W      = 5;
endpackage : scc_pkg

// ===== rtl/scc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module scc_sync
    import scc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;
    logic next_dout;

    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s2;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule // scc_sync

// ===== rtl/scc_divider.sv
// Divider, counting only while run is high, giving enable pulses at /1 /2 /4 /8 /16 /32
`timescale 1ns/1ns
module scc_divider
    import scc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 run,
    output logic [SCC_DIV_W:0]        en
);
    logic [SCC_DIV_W-1:0] cnt;
    logic [SCC_DIV_W-1:0] next_cnt;

    always_comb begin
        next_cnt = run ? cnt + 5'h01 : cnt;
    end

    // Each tap pulses when its low bits are all ones
    for (genvar i = 0; i <= SCC_DIV_W; i++) begin : g_tap
        if (i == 0) begin : g_one
            assign en[i] = run;
        end else begin : g_div
            assign en[i] = run && (&cnt[i-1:0]);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // scc_divider

// ===== rtl/scc_top.sv
// System clock control unit: registers, divider select, pin control
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module scc_top
    import scc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        wait_mode,
    input  wire logic        volt_irq_used,
    input  wire logic        wdt_protect_mode,
    input  wire logic        main_osc_failed,
    input  wire logic        port_pin_b_in,
    output logic             cpu_clk_en,
    output logic             periph_f1_en,
    output logic             periph_f2_en,
    output logic             periph_f4_en,
    output logic             periph_f8_en,
    output logic             periph_f32_en,
    output logic             main_osc_run,
    output logic             low_osc_run,
    output logic             feedback_res_on,
    output logic             crystal_drive_high,
    output logic             stop_mode,
    output logic             osc_pins_are_ports,
    output logic             clock_source_onchip,
    output logic             crystal_output_pin_o,
    output logic             crystal_output_pin_oe_b
);
    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] prot;
    logic [7:0] detect;
    logic       main_fail_sync;
    logic       pin_b_sync;
    logic [7:0] next_ctrl0;
    logic [7:0] next_ctrl1;
    logic [7:0] next_prot;
    logic [7:0] next_detect;
    logic [7:0] next_rdata;
    logic       wr0;
    logic       wr1;
    logic       stop_entry;
    logic       fast_mode;

    scc_sync u_fail_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (main_osc_failed),
        .dout  (main_fail_sync)
    );

    scc_sync u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (port_pin_b_in),
        .dout  (pin_b_sync)
    );

    always_comb begin
        wr0 = reg_wr && reg_addr == SCC_CTRL0_ADDR
              && prot[SCC_CLK_WEN];
        wr1 = reg_wr && reg_addr == SCC_CTRL1_ADDR
              && prot[SCC_CLK_WEN];
        // Running from main clock, not divide-by-8 on-chip
        fast_mode = !detect[SCC_SRC_SEL];
        stop_entry = wr1 && reg_wdata[SCC_ALL_STOP] && !ctrl1[SCC_ALL_STOP]
                     && !wdt_protect_mode && fast_mode;
    end

    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_prot  = prot;
        next_detect = detect;
        if (wr0) begin
            next_ctrl0 = (reg_wdata & SCC_CTRL0_MASK) | SCC_CTRL0_FIXED;
        end
        if (wr1) begin
            next_ctrl1 = reg_wdata & SCC_CTRL1_MASK;
            if (wdt_protect_mode) begin
                next_ctrl1[SCC_ALL_STOP] = ctrl1[SCC_ALL_STOP];
                next_ctrl1[SCC_LOW_STOP] = ctrl1[SCC_LOW_STOP];
            end
        end
        if (stop_entry) begin
            next_ctrl0[SCC_DIV_SEL0] = 1'b1;
            next_ctrl1[SCC_DRIVE]    = 1'b1;
        end
        if (reg_wr && reg_addr == SCC_PROT_ADDR) begin
            next_prot = {7'h00, reg_wdata[SCC_CLK_WEN]};
        end
        if (reg_wr && reg_addr == SCC_DETECT_ADDR) begin
            next_detect[2:0] = reg_wdata[2:0];
        end
        // Stopped status: set by failure, held at 0 when detection off
        if (main_fail_sync) begin
            next_detect[SCC_MAIN_STS] = 1'b1;
        end
        if (next_detect[SCC_DET_HI:SCC_DET_LO] == 2'b00) begin
            next_detect[SCC_MAIN_STS] = 1'b0;
        end
        // Low speed oscillator stop is the inverse of source select, held clear while volt_irq_used
        if (!next_detect[SCC_SRC_SEL]) begin
            next_ctrl1[SCC_LOW_STOP] = 1'b1;
        end else begin
            next_ctrl1[SCC_LOW_STOP] = 1'b0;
        end
        if (volt_irq_used) begin
            next_ctrl1[SCC_LOW_STOP] = 1'b0;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                SCC_CTRL0_ADDR:  next_rdata = ctrl0;
                SCC_CTRL1_ADDR:  next_rdata = ctrl1;
                SCC_PROT_ADDR:   next_rdata = prot;
                SCC_DETECT_ADDR: next_rdata = detect;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0     <= SCC_CTRL0_RST;
            ctrl1     <= SCC_CTRL1_RST;
            prot      <= 8'h00;
            detect    <= SCC_DETECT_RST;
            reg_rdata <= 8'h00;
        end else begin
            ctrl0     <= next_ctrl0;
            ctrl1     <= next_ctrl1;
            prot      <= next_prot;
            detect    <= next_detect;
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Clock division
    // ****************************************************************
    logic [SCC_DIV_W:0] taps;
    logic               sys_run;
    logic               periph_run;
    logic               next_cpu;
    logic [4:0]         next_periph;

    always_comb begin
        sys_run    = !ctrl1[SCC_ALL_STOP];
        periph_run = sys_run
                     && !(wait_mode && ctrl0[SCC_WAIT_PSTOP]);
    end

    scc_divider u_div (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (sys_run),
        .en    (taps)
    );

    always_comb begin
        if (ctrl0[SCC_DIV_SEL0]) begin
            next_cpu = taps[3];
        end else begin
            unique case (ctrl1[SCC_DIV_HI:SCC_DIV_LO])
                2'b00: next_cpu = taps[0];
                2'b01: next_cpu = taps[1];
                2'b10: next_cpu = taps[2];
                2'b11: next_cpu = taps[4];
            endcase
        end
        next_periph = periph_run ? {taps[5], taps[3:0]} : 5'h00;
    end

    // ****************************************************************
    // Oscillator and pin control
    // ****************************************************************
    logic next_crystal_output_pin_oe_b;
    logic next_crystal_output_pin;

    always_comb begin
        next_crystal_output_pin_oe_b = 1'b1;
        next_crystal_output_pin      = 1'b0;
        if (ctrl1[SCC_PIN_SWITCH]
            && (ctrl1[SCC_ALL_STOP] || ctrl0[SCC_MAIN_STOP])) begin
            next_crystal_output_pin_oe_b = 1'b0;
            next_crystal_output_pin      = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_clk_en              <= 1'b0;
            {periph_f32_en, periph_f8_en, periph_f4_en,
             periph_f2_en, periph_f1_en} <= 5'h00;
            main_osc_run            <= 1'b0;
            low_osc_run             <= 1'b1;
            feedback_res_on         <= 1'b1;
            crystal_drive_high      <= 1'b1;
            stop_mode               <= 1'b0;
            osc_pins_are_ports      <= 1'b1;
            clock_source_onchip     <= 1'b1;
            crystal_output_pin_o    <= 1'b0;
            crystal_output_pin_oe_b <= 1'b1;
        end else begin
            cpu_clk_en              <= next_cpu;
            {periph_f32_en, periph_f8_en, periph_f4_en,
             periph_f2_en, periph_f1_en} <= next_periph;
            main_osc_run            <= !ctrl0[SCC_MAIN_STOP]
                                       && sys_run;
            low_osc_run             <= !ctrl1[SCC_LOW_STOP] && sys_run;
            feedback_res_on         <= sys_run;
            crystal_drive_high      <= ctrl1[SCC_DRIVE];
            stop_mode               <= ctrl1[SCC_ALL_STOP];
            osc_pins_are_ports      <= !ctrl1[SCC_PIN_SWITCH]
                                       || ctrl0[SCC_MAIN_STOP];
            clock_source_onchip     <= detect[SCC_SRC_SEL];
            crystal_output_pin_o    <= next_crystal_output_pin;
            crystal_output_pin_oe_b <= next_crystal_output_pin_oe_b;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_write_guard: assert property (@(posedge clk)
        disable iff (!rst_b)
        (reg_wr && reg_addr == SCC_CTRL0_ADDR && !prot[SCC_CLK_WEN])
        |=> $stable(ctrl0))
        else $error("Control 0 changed without write enable");
    a_div8_select: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl0[SCC_DIV_SEL0] && sys_run && taps[3] |=> cpu_clk_en)
        else $error("Divide-by-8 pulse missing");
    a_div16_select: assert property (@(posedge clk)
        disable iff (!rst_b)
        !ctrl0[SCC_DIV_SEL0] && ctrl1[SCC_DIV_HI:SCC_DIV_LO] == 2'b11
        && taps[4] |=> cpu_clk_en)
        else $error("Divide-by-16 pulse missing");
    a_stop_entry: assert property (@(posedge clk)
        disable iff (!rst_b)
        stop_entry |=> ctrl0[SCC_DIV_SEL0] && ctrl1[SCC_DRIVE])
        else $error("Stop entry did not force divide and drive");
    a_low_osc_src: assert property (@(posedge clk)
        disable iff (!rst_b)
        detect[SCC_SRC_SEL] |-> !ctrl1[SCC_LOW_STOP])
        else $error("Low speed stop set with on-chip source");
    a_low_osc_off: assert property (@(posedge clk)
        disable iff (!rst_b)
        !next_detect[SCC_SRC_SEL] && !volt_irq_used |=> ctrl1[SCC_LOW_STOP])
        else $error("Low speed stop clear with main source");
    a_volt_low_osc: assert property (@(posedge clk)
        disable iff (!rst_b)
        volt_irq_used |=> !ctrl1[SCC_LOW_STOP])
        else $error("Low speed stop set while voltage detect used");
    a_status_hold: assert property (@(posedge clk)
        disable iff (!rst_b)
        detect[SCC_DET_HI:SCC_DET_LO] == 2'b00 |-> !detect[SCC_MAIN_STS])
        else $error("Stopped status set while detection off");
    a_protect_hold: assert property (@(posedge clk)
        disable iff (!rst_b)
        wdt_protect_mode && wr1 && !volt_irq_used
        && $stable(detect[SCC_SRC_SEL]) |=> $stable(ctrl1[SCC_ALL_STOP]))
        else $error("All stop changed in protect mode");
    a_wait_gate: assert property (@(posedge clk)
        disable iff (!rst_b)
        wait_mode && ctrl0[SCC_WAIT_PSTOP] |=> !periph_f1_en)
        else $error("Peripheral clock ran in wait");
    a_wait_run: assert property (@(posedge clk)
        disable iff (!rst_b)
        sys_run && !wait_mode |=> periph_f1_en)
        else $error("Peripheral clock stopped outside wait");
    a_main_osc_off: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl0[SCC_MAIN_STOP] |=> !main_osc_run)
        else $error("Main oscillator ran while stopped");
    a_pins_free: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl0[SCC_MAIN_STOP] |=> osc_pins_are_ports)
        else $error("Oscillator pins not ports with main stopped");
    a_crystal_output_pin_high: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl1[SCC_PIN_SWITCH] && ctrl0[SCC_MAIN_STOP]
        |=> !crystal_output_pin_oe_b && crystal_output_pin_o)
        else $error("Crystal output not driven high");
    a_stop_clocks: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl1[SCC_ALL_STOP] |=> !cpu_clk_en && stop_mode)
        else $error("Clock pulse seen in stop mode");
    a_feedback_off: assert property (@(posedge clk)
        disable iff (!rst_b)
        ctrl1[SCC_ALL_STOP] |=> !feedback_res_on && !main_osc_run)
        else $error("Feedback resistor on in stop mode");
    a_source_out: assert property (@(posedge clk)
        disable iff (!rst_b)
        detect[SCC_SRC_SEL] |=> clock_source_onchip)
        else $error("Source output not on-chip");
endmodule // scc_top

// ===== tb/scc_bench.sv
// Self-checking bench for the system clock control unit
`timescale 1ns/1ns
module scc_bench
    import scc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        wait_mode = 1'b0;
    logic        volt_irq_used = 1'b0;
    logic        wdt_protect_mode = 1'b0;
    logic        main_osc_failed = 1'b0;
    logic        port_pin_b_in = 1'b0;
    logic        cpu_clk_en, periph_f1_en, periph_f2_en, periph_f4_en;
    logic        periph_f8_en, periph_f32_en, main_osc_run, low_osc_run;
    logic        feedback_res_on, crystal_drive_high, stop_mode;
    logic        osc_pins_are_ports, clock_source_onchip;
    logic        crystal_output_pin_o, crystal_output_pin_oe_b;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    int          cnt [6];
    logic [7:0]  r;
    logic [7:0]  pexp [6] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    logic [7:0]  dexp [4] = '{8'h40, 8'h20, 8'h10, 8'h04};

    initial begin
        forever #2 clk = ~clk;
    end

    scc_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wait_mode(wait_mode),
        .volt_irq_used(volt_irq_used), .wdt_protect_mode(wdt_protect_mode),
        .main_osc_failed(main_osc_failed), .port_pin_b_in(port_pin_b_in),
        .cpu_clk_en(cpu_clk_en), .periph_f1_en(periph_f1_en),
        .periph_f2_en(periph_f2_en), .periph_f4_en(periph_f4_en),
        .periph_f8_en(periph_f8_en), .periph_f32_en(periph_f32_en),
        .main_osc_run(main_osc_run), .low_osc_run(low_osc_run),
        .feedback_res_on(feedback_res_on),
        .crystal_drive_high(crystal_drive_high), .stop_mode(stop_mode),
        .osc_pins_are_ports(osc_pins_are_ports),
        .clock_source_onchip(clock_source_onchip),
        .crystal_output_pin_o(crystal_output_pin_o),
        .crystal_output_pin_oe_b(crystal_output_pin_oe_b));

    // ****************************************
    // Compare, report and bus tasks
    // ****************************************
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] b(input logic v);
        return {7'h00, v};
    endfunction

    task automatic end_sim();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            cmp(reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr        <= 1'b1;
        reg_addr      <= a;
        reg_wdata     <= d;
        port_pin_b_in <= 1'($urandom);
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Whole count windows give exact pulse totals at any phase
    task automatic count_en();
        repeat (4) @(posedge clk);
        cnt = '{default: 0};
        repeat (64) begin
            @(posedge clk);
            cnt[0] += int'(cpu_clk_en === 1'b1);
            cnt[1] += int'(periph_f1_en === 1'b1);
            cnt[2] += int'(periph_f2_en === 1'b1);
            cnt[3] += int'(periph_f4_en === 1'b1);
            cnt[4] += int'(periph_f8_en === 1'b1);
            cnt[5] += int'(periph_f32_en === 1'b1);
        end
    endtask

    task automatic cmp_per(input logic run);
        for (int i = 1; i < 6; i++) begin
            cmp(8'(cnt[i]), run ? pexp[i] : 8'h00);
        end
    endtask

    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(75037));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(SCC_CTRL0_ADDR, SCC_CTRL0_RST);
        rd(SCC_CTRL1_ADDR, SCC_CTRL1_RST);
        rd(16'h000b, 8'h00);
        settle();
        cmp(b(main_osc_run), 8'h00);
        cmp(b(clock_source_onchip), 8'h01);
        count_en();
        cmp(8'(cnt[0]), 8'h08);
        $display("test reset done");
        r = 8'($urandom) & 8'hbf;
        wr(SCC_CTRL0_ADDR, r);
        rd(SCC_CTRL0_ADDR, SCC_CTRL0_RST);
        wr(SCC_PROT_ADDR, 8'h01);
        wr(SCC_CTRL0_ADDR, r);
        rd(SCC_CTRL0_ADDR, (r & SCC_CTRL0_MASK) | 8'h08);
        wr(SCC_CTRL0_ADDR, 8'h00);
        settle();
        cmp(b(main_osc_run), 8'h01);
        $display("test protect done");
        for (int f = 0; f < 4; f++) begin
            r = {2'(f), 6'h20};
            wr(SCC_CTRL1_ADDR, r);
            rd(SCC_CTRL1_ADDR, r);
            count_en();
            cmp(8'(cnt[0]), dexp[f]);
        end
        wr(SCC_CTRL0_ADDR, 8'h40);
        count_en();
        cmp(8'(cnt[0]), 8'h08);
        cmp_per(1'b1);
        wr(SCC_CTRL0_ADDR, 8'h04);
        wait_mode <= 1'b1;
        count_en();
        cmp_per(1'b0);
        wr(SCC_CTRL0_ADDR, 8'h00);
        count_en();
        cmp_per(1'b1);
        wait_mode <= 1'b0;
        $display("test divider done");
        wr(SCC_CTRL1_ADDR, 8'h28);
        settle();
        cmp(b(osc_pins_are_ports), 8'h00);
        wr(SCC_CTRL0_ADDR, 8'h20);
        settle();
        cmp(b(osc_pins_are_ports), 8'h01);
        cmp(b(crystal_output_pin_o), 8'h01);
        cmp(b(crystal_output_pin_oe_b), 8'h00);
        wr(SCC_CTRL1_ADDR, 8'h20);
        settle();
        cmp(b(crystal_output_pin_oe_b), 8'h01);
        $display("test pins done");
        @(posedge clk);
        main_osc_failed <= 1'b1;
        repeat (8) @(posedge clk);
        rd(SCC_DETECT_ADDR, SCC_DETECT_RST);
        wr(SCC_DETECT_ADDR, 8'h07);
        rd(SCC_DETECT_ADDR, 8'h0f);
        main_osc_failed <= 1'b0;
        wr(SCC_DETECT_ADDR, 8'h04);
        rd(SCC_DETECT_ADDR, SCC_DETECT_RST);
        wdt_protect_mode <= 1'b1;
        wr(SCC_CTRL1_ADDR, 8'h21);
        rd(SCC_CTRL1_ADDR, 8'h20);
        wdt_protect_mode <= 1'b0;
        wr(SCC_CTRL0_ADDR, 8'h00);
        wr(SCC_DETECT_ADDR, 8'h00);
        rd(SCC_CTRL1_ADDR, 8'h30);
        settle();
        cmp(b(low_osc_run), 8'h00);
        cmp(b(clock_source_onchip), 8'h00);
        @(posedge clk);
        volt_irq_used <= 1'b1;
        rd(SCC_CTRL1_ADDR, 8'h20);
        settle();
        cmp(b(low_osc_run), 8'h01);
        @(posedge clk);
        volt_irq_used <= 1'b0;
        $display("test source done");
        wr(SCC_CTRL1_ADDR, 8'h00);
        settle();
        cmp(b(crystal_drive_high), 8'h00);
        cmp(b(feedback_res_on), 8'h01);
        wr(SCC_CTRL1_ADDR, 8'h01);
        settle();
        cmp(b(stop_mode), 8'h01);
        cmp(b(feedback_res_on), 8'h00);
        cmp(b(crystal_drive_high), 8'h01);
        rd(SCC_CTRL0_ADDR, 8'h48);
        rd(SCC_CTRL1_ADDR, 8'h31);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(SCC_CTRL0_ADDR, SCC_CTRL0_RST);
        $display("test stop done");
        for (int k = 0; k < 10 && exp_q.size() > 0; k++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            miscompares++;
        end
        end_sim();
    end
endmodule // scc_bench
